/* File: gphy_np_ms_regs.v */
`timescale 1ns/1ns
`include "gphy_np_ms_map.vh"
// Function
// - Bit15 more pages; bit13 formatted page
// - Writable second-acknowledge bit, resets zero
// - Toggle read-only, inverse of next to send
// - Low eleven bits writable, reset 0x3FF
// - Partner next page read-only, resets zero
// - Manual enable selects manual master/slave
// - Value forces master/slave only when manual
// - Port type advertises master preference
// - Full-duplex advertised only when bit set
// - Half-duplex advertised only when bit set
// - Fault latched until read/reset/negotiation event
// - Resolution bit reports master or slave
// - Local receiver status bit read-only
// - Remote receiver status bit read-only
// - Partner gigabit full/half ability bits
// - Idle errors counted when both receivers good
// - Idle error counter saturates at 255
// - Counter clears on status read or reset
module gphy_np_ms_regs (
   input  wire        i_clk_sys,
   input  wire        i_rst,
   input  wire        i_ce,
   // Management register port
   input  wire [4:0]  i_reg_addr,
   input  wire        i_reg_wr,
   input  wire        i_reg_rd,
   input  wire [15:0] i_reg_wdata,
   output reg  [15:0] o_reg_rdata,
   output reg         o_reg_rvalid,
   // Negotiation engine events (same clock)
   input  wire        i_np_sent,
   input  wire        i_np_rx_valid,
   input  wire [15:0] i_np_rx_word,
   input  wire        i_lp_gig_valid,
   input  wire        i_lp_gig_fd,
   input  wire        i_lp_gig_hd,
   input  wire        i_an_complete,
   input  wire        i_an_enable_set,
   input  wire        i_ms_fault_det,
   input  wire        i_ms_resolved_master,
   // Line-side status from the PMA (asynchronous)
   input  wire        i_local_rx_ok,
   input  wire        i_remote_rx_ok,
   input  wire        i_idle_err,
   // Controls toward negotiation and PMA
   output reg  [15:0] o_np_tx_word,
   output reg  [2:0]  o_test_mode,
   output reg         o_test_active,
   output reg         o_ms_manual,
   output reg         o_ms_force_master,
   output reg         o_port_multi,
   output reg         o_adv_gig_fd,
   output reg         o_adv_gig_hd
);
   // Transmit next-page register fields
   reg        np_more_q;      // More pages follow
   reg        np_msg_q;       // Formatted page
   reg        np_ack2_q;      // Able to comply
   reg        np_toggle_q;    // Hardware toggle
   reg [10:0] np_code_q;      // Message or data
   // Partner next page capture
   reg [15:0] np_partner_q;
   // Gigabit control register
   reg [15:0] gig_ctrl_q;
   // Gigabit status state
   reg        ms_fault_q;     // Latched fault
   reg        ms_master_q;    // Resolution
   reg        lp_fd_q;        // Partner full-duplex
   reg        lp_hd_q;        // Partner half-duplex
   // Synchronised line inputs
   wire [2:0] line_sync;
   wire       local_ok;
   wire       remote_ok;
   wire       idle_err_s;
   reg        idle_err_prev_q; // Edge detect on synced error
   wire       idle_err_evt;
   wire [7:0] idle_count;
   // Decoded accesses
   wire       wr_np_tx;
   wire       wr_gig_ctrl;
   wire       rd_gig_stat;
   reg [15:0] rd_mux;

   assign wr_np_tx    = i_reg_wr && (i_reg_addr == `REG_NP_TX_ADDR);
   assign wr_gig_ctrl = i_reg_wr && (i_reg_addr == `REG_GIG_CTRL_ADDR);
   assign rd_gig_stat = i_ce && i_reg_rd &&
                        (i_reg_addr == `REG_GIG_STAT_ADDR);

   // Line status passes the three-stage filter
   sync3 #(
      .W (3)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_async   ({i_idle_err, i_remote_rx_ok, i_local_rx_ok}),
      .o_sync    (line_sync)
   );
   assign local_ok   = line_sync[0];
   assign remote_ok  = line_sync[1];
   assign idle_err_s = line_sync[2];

   // One count per idle error pulse
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         idle_err_prev_q <= 1'b0;
      end else if (i_ce) begin
         idle_err_prev_q <= idle_err_s;
      end
   end
   assign idle_err_evt = idle_err_s && !idle_err_prev_q;

   // Saturating idle error counter
   idle_err_counter #(
      .W (8)
   ) u_idle_cnt (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_err     (idle_err_evt),
      .i_enable  (local_ok && remote_ok),
      .i_clear   (rd_gig_stat),
      .o_count   (idle_count)
   );

   // Transmit next-page register
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         np_more_q   <= `NP_MORE_RST;
         np_msg_q    <= `NP_MSG_RST;
         np_ack2_q   <= `NP_ACK2_RST;
         np_toggle_q <= 1'b0;
         np_code_q   <= `NP_CODE_RST;
      end else if (i_ce) begin
         if (wr_np_tx) begin
            np_more_q <= i_reg_wdata[`NP_MORE_BIT];
            np_msg_q  <= i_reg_wdata[`NP_MSG_BIT];
            np_ack2_q <= i_reg_wdata[`NP_ACK2_BIT];
            np_code_q <= i_reg_wdata[`NP_CODE_MSB:0];
         end
         // Toggle flips after each sent code word
         if (i_np_sent) begin
            np_toggle_q <= ~np_toggle_q;
         end
      end
   end

   // Partner next-page capture
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         np_partner_q <= `NP_PARTNER_RST;
      end else if (i_ce && i_np_rx_valid) begin
         np_partner_q <= i_np_rx_word;
      end
   end

   // Gigabit control register; reserved low byte kept zero
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         gig_ctrl_q <= `GC_RST;
      end else if (i_ce && wr_gig_ctrl) begin
         gig_ctrl_q <= {i_reg_wdata[15:8], 8'h00};
      end
   end

   // Fault latch: detection wins over a read or negotiation clear; reset wins over detection
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         ms_fault_q <= 1'b0;
      end else if (i_ce) begin
         if (i_ms_fault_det) begin
            ms_fault_q <= 1'b1;
         end else if (rd_gig_stat || i_an_complete ||
                      i_an_enable_set) begin
            ms_fault_q <= 1'b0;
         end
      end
   end

   // Resolution and partner gigabit abilities
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         ms_master_q <= 1'b0;
         lp_fd_q     <= 1'b0;
         lp_hd_q     <= 1'b0;
      end else if (i_ce) begin
         ms_master_q <= i_ms_resolved_master;
         if (i_lp_gig_valid) begin
            lp_fd_q <= i_lp_gig_fd;
            lp_hd_q <= i_lp_gig_hd;
         end
      end
   end

   // Read data selection; unmapped addresses read zero
   always @* begin
      rd_mux = 16'h0000;
      if (i_reg_addr == `REG_NP_TX_ADDR) begin
         rd_mux = {np_more_q, 1'b0, np_msg_q, np_ack2_q,
                   ~np_toggle_q, np_code_q};
      end else if (i_reg_addr == `REG_NP_PARTNER_ADDR) begin
         rd_mux = np_partner_q;
      end else if (i_reg_addr == `REG_GIG_CTRL_ADDR) begin
         rd_mux = gig_ctrl_q;
      end else if (i_reg_addr == `REG_GIG_STAT_ADDR) begin
         rd_mux = {ms_fault_q, ms_master_q, local_ok, remote_ok,
                   lp_fd_q, lp_hd_q, 2'b00, idle_count};
      end
   end

   // Registered read answer, one cycle after the strobe
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_reg_rdata  <= 16'h0000;
         o_reg_rvalid <= 1'b0;
      end else if (i_ce) begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
         end
      end
   end

   // Control outputs toward negotiation and PMA
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_np_tx_word      <= 16'h0000;
         o_test_mode       <= `TM_NORMAL;
         o_test_active     <= 1'b0;
         o_ms_manual       <= 1'b0;
         o_ms_force_master <= 1'b0;
         o_port_multi      <= 1'b0;
         o_adv_gig_fd      <= 1'b0;
         o_adv_gig_hd      <= 1'b0;
      end else if (i_ce) begin
         o_np_tx_word <= {np_more_q, 1'b0, np_msg_q, np_ack2_q,
                          np_toggle_q, np_code_q};
         // Reserved codes fall back to normal operation
         case (gig_ctrl_q[`GC_TEST_MSB:`GC_TEST_LSB])
            `TM_WAVEFORM, `TM_MASTER_JIT, `TM_SLAVE_JIT,
            `TM_DISTORTION: begin
               o_test_mode   <= gig_ctrl_q[`GC_TEST_MSB:`GC_TEST_LSB];
               o_test_active <= 1'b1;
            end
            default: begin
               o_test_mode   <= `TM_NORMAL;
               o_test_active <= 1'b0;
            end
         endcase
         o_ms_manual       <= gig_ctrl_q[`GC_MS_MAN_BIT];
         o_ms_force_master <= gig_ctrl_q[`GC_MS_MAN_BIT] &&
                              gig_ctrl_q[`GC_MS_VAL_BIT];
         o_port_multi      <= gig_ctrl_q[`GC_PORT_BIT];
         o_adv_gig_fd      <= gig_ctrl_q[`GC_ADV_FD_BIT];
         o_adv_gig_hd      <= gig_ctrl_q[`GC_ADV_HD_BIT];
      end
   end
endmodule

/* File: gphy_np_ms_map.vh */
`ifndef GPHY_NP_MS_MAP_VH
`define GPHY_NP_MS_MAP_VH
// Register addresses on the management port
`define REG_NP_TX_ADDR      5'h07
`define REG_NP_PARTNER_ADDR 5'h08
`define REG_GIG_CTRL_ADDR   5'h09
`define REG_GIG_STAT_ADDR   5'h0A
// Next-page field positions
`define NP_MORE_BIT     15
`define NP_ACK_BIT      14
`define NP_MSG_BIT      13
`define NP_ACK2_BIT     12
`define NP_TOGGLE_BIT   11
`define NP_CODE_MSB     10
// Next-page transmit and partner reset values
`define NP_MORE_RST     1'b0
`define NP_MSG_RST      1'b1
`define NP_ACK2_RST     1'b0
`define NP_CODE_RST     11'h03FF
`define NP_PARTNER_RST  16'h0000
// Gigabit control fields
`define GC_TEST_MSB     15
`define GC_TEST_LSB     13
`define GC_MS_MAN_BIT   12
`define GC_MS_VAL_BIT   11
`define GC_PORT_BIT     10
`define GC_ADV_FD_BIT   9
`define GC_ADV_HD_BIT   8
`define GC_RST          16'h0000
// Test mode codes
`define TM_NORMAL       3'h0
`define TM_WAVEFORM     3'h1
`define TM_MASTER_JIT   3'h2
`define TM_SLAVE_JIT    3'h3
`define TM_DISTORTION   3'h4
// Gigabit status fields
`define GS_FAULT_BIT    15
`define GS_RES_BIT      14
`define GS_LRX_BIT      13
`define GS_RRX_BIT      12
`define GS_LP_FD_BIT    11
`define GS_LP_HD_BIT    10
`define IDLE_ERR_MAX    8'hFF
`endif

/* File: sync3.v */
`timescale 1ns/1ns
// Three-stage synchroniser; output changes when stages two and three agree
module sync3 #(
   parameter W = 1
) (
   input  wire         i_clk_sys,
   input  wire         i_rst,
   input  wire         i_ce,
   input  wire [W-1:0] i_async,
   output reg  [W-1:0] o_sync
);
   reg [W-1:0] s1_q;   // Metastability catcher
   reg [W-1:0] s2_q;   // Second stage
   reg [W-1:0] s3_q;   // Third stage
   genvar g;

   // Shift chain
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
      end else if (i_ce) begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Per-bit agreement filter
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         always @(posedge i_clk_sys) begin
            if (i_rst) begin
               o_sync[g] <= 1'b0;
            end else if (i_ce && (s2_q[g] == s3_q[g])) begin
               o_sync[g] <= s3_q[g];
            end
         end
      end
   endgenerate
endmodule

/* File: idle_err_counter.v */
`timescale 1ns/1ns
`include "gphy_np_ms_map.vh"
// Saturating idle error counter with clear
module idle_err_counter #(
   parameter W = 8
) (
   input  wire         i_clk_sys,
   input  wire         i_rst,
   input  wire         i_ce,
   input  wire         i_err,
   input  wire         i_enable,
   input  wire         i_clear,
   output reg  [W-1:0] o_count
);
   // Counter update; a read clears even if an error lands
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_count <= {W{1'b0}};
      end else if (i_ce) begin
         if (i_clear) begin
            o_count <= {W{1'b0}};
         end else if (i_err && i_enable && (o_count != {W{1'b1}})) begin
            o_count <= o_count + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

/* File: gphy_regs_monitor.sv */
`timescale 1ns/1ns
// Port-level checker for the gigabit next-page and control registers
module gphy_regs_chk (
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic        i_ce,
   input wire logic [4:0]  i_reg_addr,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   input wire logic        o_reg_rvalid,
   input wire logic        i_np_sent,
   input wire logic [15:0] o_np_tx_word,
   input wire logic [2:0]  o_test_mode,
   input wire logic        o_ms_manual,
   input wire logic        o_ms_force_master,
   input wire logic        o_port_multi,
   input wire logic        o_adv_gig_fd
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // Accepted writes, decoded per register
   wire w7 = i_ce && i_reg_wr && i_reg_addr == 5'h07;
   wire w9 = i_ce && i_reg_wr && i_reg_addr == 5'h09;
   property p_code; w7 ##2 1 |-> o_np_tx_word[10:0] == $past(i_reg_wdata[10:0], 2); endproperty
   a_code: assert property (p_code) else $error("code field lost");
   property p_ack2; w7 ##2 1 |-> o_np_tx_word[12] == $past(i_reg_wdata[12], 2); endproperty
   a_ack2: assert property (p_ack2) else $error("ack2 lost");
   property p_tog; i_ce && i_np_sent |-> ##[1:2] $changed(o_np_tx_word[11]); endproperty
   a_tog: assert property (p_tog) else $error("toggle stuck");
   property p_tm_rng; o_test_mode <= 3'h4; endproperty
   a_tm_rng: assert property (p_tm_rng) else $error("reserved test mode out");
   property p_tm; w9 && i_reg_wdata[15:13] < 3'h5 ##2 1 |-> o_test_mode == $past(i_reg_wdata[15:13], 2); endproperty
   a_tm: assert property (p_tm) else $error("test mode wrong");
   property p_man; w9 ##2 1 |-> o_ms_manual == $past(i_reg_wdata[12], 2); endproperty
   a_man: assert property (p_man) else $error("manual enable wrong");
   property p_force; o_ms_force_master |-> o_ms_manual; endproperty
   a_force: assert property (p_force) else $error("force without manual");
   property p_port; w9 ##2 1 |-> o_port_multi == $past(i_reg_wdata[10], 2); endproperty
   a_port: assert property (p_port) else $error("port type wrong");
   property p_fd; w9 ##2 1 |-> o_adv_gig_fd == $past(i_reg_wdata[9], 2); endproperty
   a_fd: assert property (p_fd) else $error("fd advert wrong");
   property p_lo; i_ce && i_reg_rd && i_reg_addr == 5'h09 |=> o_reg_rvalid && o_reg_rdata[7:0] == 8'h00; endproperty
   a_lo: assert property (p_lo) else $error("reserved byte nonzero");
   c_rd: cover property (o_reg_rvalid);
   c_tm: cover property (o_test_mode == 3'h4);
   c_fm: cover property (o_ms_force_master);
endmodule
bind gphy_np_ms_regs gphy_regs_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_ce(i_ce), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .i_np_sent(i_np_sent), .o_np_tx_word(o_np_tx_word), .o_test_mode(o_test_mode),
   .o_ms_manual(o_ms_manual), .o_ms_force_master(o_ms_force_master),
   .o_port_multi(o_port_multi), .o_adv_gig_fd(o_adv_gig_fd));

/* File: line_side_model.sv */
`timescale 1ns/1ns
// Line side: receiver health levels and idle error bursts
module line_side_model (
   input  wire logic i_clk_sys,
   output logic      o_local_rx_ok,
   output logic      o_remote_rx_ok,
   output logic      o_idle_err
);
   initial begin
      o_local_rx_ok = 1'b0;
      o_remote_rx_ok = 1'b0;
      o_idle_err = 1'b0;
   end
   // Set both receiver health levels
   task set_ok(input logic l, input logic r);
      @(posedge i_clk_sys);
      o_local_rx_ok <= l;
      o_remote_rx_ok <= r;
   endtask
   // Wide pulses so each survives the synchroniser
   task burst(input int n);
      repeat (n) begin
         @(posedge i_clk_sys) o_idle_err <= 1'b1;
         repeat (5) @(posedge i_clk_sys);
         o_idle_err <= 1'b0;
         repeat (5) @(posedge i_clk_sys);
      end
   endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ns
`include "gphy_np_ms_map.vh"
module tb_top;
   logic clk, rst, wr, rd, lp_fd, master;
   logic [4:0]  addr;
   logic [15:0] wdata, rx_word, got, rdata, np_word;
   logic [5:0]  ev;     // fault, an_en, an_done, lp_valid, rx_valid, sent
   logic [2:0]  tmode;
   logic        rvalid, tact, man, fm, pm, afd, ahd, lok, rok, ierr;
   int err_count = 0, tests_run = 0, cyc = 0, i;
   initial begin clk = 0; forever #2 clk = ~clk; end
   initial begin rst = 1; wr = 0; rd = 0; addr = 0; wdata = 0; ev = 0;
      rx_word = 0; lp_fd = 0; master = 0; end
   line_side_model line (.i_clk_sys(clk), .o_local_rx_ok(lok),
      .o_remote_rx_ok(rok), .o_idle_err(ierr));
   gphy_np_ms_regs uut (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_np_sent(ev[0]),
      .i_np_rx_valid(ev[1]), .i_np_rx_word(rx_word), .i_lp_gig_valid(ev[2]),
      .i_lp_gig_fd(lp_fd), .i_lp_gig_hd(1'b0), .i_an_complete(ev[3]),
      .i_an_enable_set(ev[4]), .i_ms_fault_det(ev[5]),
      .i_ms_resolved_master(master), .i_local_rx_ok(lok),
      .i_remote_rx_ok(rok), .i_idle_err(ierr), .o_np_tx_word(np_word),
      .o_test_mode(tmode), .o_test_active(tact), .o_ms_manual(man),
      .o_ms_force_master(fm), .o_port_multi(pm), .o_adv_gig_fd(afd),
      .o_adv_gig_hd(ahd));
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin err_count = err_count + 1; final_report; end
   end
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task check(input string nm, input logic [15:0] seen, exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
      @(posedge clk) wr <= 0;
   endtask
   // Read; data must come with the valid pulse
   task rd_reg(input logic [4:0] a);
      @(posedge clk) begin rd <= 1; addr <= a; end
      @(posedge clk) rd <= 0;
      #1 got = (rvalid === 1'b1) ? rdata : 16'hxxxx;
   endtask
   task rd_chk(input logic [4:0] a, input logic [15:0] exp);
      rd_reg(a);
      check("rdata", got, exp);
   endtask
   task pulse(input logic [5:0] m);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 0;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 0;
      rd_chk(`REG_NP_TX_ADDR, 16'h2bff);
      rd_chk(`REG_NP_PARTNER_ADDR, 16'h0000);
      rd_chk(`REG_GIG_CTRL_ADDR, 16'h0000);
      rd_chk(`REG_GIG_STAT_ADDR, 16'h0000);
      wr_reg(`REG_NP_TX_ADDR, 16'hffff);
      rd_chk(`REG_NP_TX_ADDR, 16'hbfff);
      pulse(6'h01);
      rd_chk(`REG_NP_TX_ADDR, 16'hb7ff);
      pulse(6'h01);
      wr_reg(`REG_NP_TX_ADDR, 16'h0000);
      rd_chk(`REG_NP_TX_ADDR, 16'h0800);
      wr_reg(`REG_NP_PARTNER_ADDR, 16'hffff);
      rd_chk(`REG_NP_PARTNER_ADDR, 16'h0000);
      rx_word <= 16'ha5a5;
      pulse(6'h02);
      rd_chk(`REG_NP_PARTNER_ADDR, 16'ha5a5);
      rd_chk(5'h1f, 16'h0000);
      for (i = 0; i < 8; i++) begin
         wr_reg(`REG_GIG_CTRL_ADDR, {i[2:0], 13'h0000});
         @(posedge clk);
         #1;
         check("tmode", {13'h0000, tmode}, (i < 5) ? i[15:0] : 16'h0000);
         check("tact", {15'h0000, tact}, (i > 0 && i < 5) ? 16'h0001 : 16'h0000);
      end
      wr_reg(`REG_GIG_CTRL_ADDR, 16'h0800);
      rd_chk(`REG_GIG_CTRL_ADDR, 16'h0800);
      check("ms", {man, fm}, 16'h0000);
      wr_reg(`REG_GIG_CTRL_ADDR, 16'h1800);
      rd_chk(`REG_GIG_CTRL_ADDR, 16'h1800);
      check("ms", {man, fm}, 16'h0003);
      wr_reg(`REG_GIG_CTRL_ADDR, 16'h0700);
      rd_chk(`REG_GIG_CTRL_ADDR, 16'h0700);
      check("adv", {pm, afd, ahd, man}, 16'h000e);
      line.set_ok(1, 1);
      lp_fd <= 1;
      master <= 1;
      pulse(6'h04);
      line.burst(3);
      repeat (10) @(posedge clk);
      rd_chk(`REG_GIG_STAT_ADDR, 16'h7803);
      rd_chk(`REG_GIG_STAT_ADDR, 16'h7800);
      line.burst(260);
      repeat (10) @(posedge clk);
      rd_chk(`REG_GIG_STAT_ADDR, 16'h78ff);
      line.set_ok(1, 0);
      master <= 0;
      repeat (10) @(posedge clk);
      line.burst(2);
      repeat (10) @(posedge clk);
      rd_chk(`REG_GIG_STAT_ADDR, 16'h2800);
      pulse(6'h20);
      repeat (5) @(posedge clk);
      rd_reg(`REG_GIG_STAT_ADDR);
      check("fault", got & 16'hbfff, 16'ha800);
      rd_chk(`REG_GIG_STAT_ADDR, 16'h2800);
      for (i = 0; i < 2; i++) begin
         pulse(6'h20);
         pulse(i ? 6'h10 : 6'h08);
         rd_chk(`REG_GIG_STAT_ADDR, 16'h2800);
      end
      final_report;
   end
endmodule
